// >>> core/ccp_params.svh
/*
  Constants for the control-channel proxy and status block: register
  offsets, field positions, reset values and timing figures.
  Assumes a 20 MHz core clock; included by bare name from the core files.
*/
// Behaviour
// RULE_01: two-bit code delays SDA output after SCL in 40 ns steps, 240 to 360 ns.
// RULE_02: remote-write block bit rejects far-end writes to local registers.
// RULE_03: remote-write block leaves far-end access to local I2C slaves untouched.
// RULE_04: watchdog speedup bit selects about 50 ms expiry, else about 1 s.
// RULE_05: watchdog disable bit stops idle detection and bus recovery completely.
// RULE_06: SDA high with no activity for the period marks the bus free.
// RULE_07: SDA low with no activity for the period drives nine SCL clocks.
// RULE_08: seven-bit peer address of zero disables all access to the far end.
// RULE_09: receive lock auto-loads the peer address unless the hold bit is set.
// RULE_10: hold bit keeps the written peer address and blocks auto-reload.
// RULE_11: software writing the peer address should also set the hold bit.
// RULE_12: alias-addressed transactions are forwarded with the remote target address instead.
// RULE_13: alias address of zero disables access to the remote target.
// RULE_14: sixteen-bit read-only back-channel CRC error count, low and high bytes.
// RULE_15: self-test error flag sets on CRC error, clears on link loss, restart, reset.
// RULE_16: status bit reads 1 while a valid pixel clock is seen.
// RULE_17: normal error flag sets on CRC error, clears on link loss or reset.
// RULE_18: status bit reads 1 while a cable link is seen, 0 is a fault.
// RULE_19: CRC reset bit clears the counters while 1; it does not self-clear.
`ifndef CCP_PARAMS_SVH
`define CCP_PARAMS_SVH

// register offsets
`define CCP_OFF_CFG 8'h04
`define CCP_OFF_BUS 8'h05
`define CCP_OFF_PEER 8'h06
`define CCP_OFF_TGT 8'h07
`define CCP_OFF_ALIAS 8'h08
`define CCP_OFF_CNT_LO 8'h0A
`define CCP_OFF_CNT_HI 8'h0B
`define CCP_OFF_STAT 8'h0C

// field positions
`define CCP_CRC_RST_BIT 5
`define CCP_SDA_DLY_HI 4
`define CCP_SDA_DLY_LO 3
`define CCP_WR_BLK_BIT 2
`define CCP_WD_FAST_BIT 1
`define CCP_WD_DIS_BIT 0
`define CCP_HOLD_BIT 0
`define CCP_ST_SELF 3
`define CCP_ST_PCLK 2
`define CCP_ST_DES 1
`define CCP_ST_LINK 0

// reset and fixed values
`define CCP_RST_BYTE 8'h00
`define CCP_RST_ADDR 7'h00
`define CCP_RST_CNT 16'h0000
`define CCP_CNT_MAX 16'hFFFF

// timing
`define CCP_CLK_NS 50
`define CCP_CLK_KHZ 20000
`define CCP_SDA_BASE_NS 240
`define CCP_SDA_STEP_NS 40
`define CCP_WD_LONG_MS 1000
`define CCP_WD_SHORT_MS 50
`define CCP_WD_PULSES 9
`define CCP_WD_HALF_NS 5000

`endif

// >>> core/ccp_pkg.sv
/*
  Types shared by the control-channel proxy block.
  Assumes nothing of its surroundings.
*/
package ccp_pkg;
  // bus watchdog phases: watching, SCL held low, SCL released
  typedef enum logic [1:0] {ccp_wd_watch, ccp_wd_low, ccp_wd_high} ccp_wd_state_t;
  typedef logic [6:0] ccp_addr_t;
endpackage

// >>> core/ccp_sync2.sv
/*
  Two-flop synchroniser for a bundle of independent levels.
  Assumes each bit changes slowly next to the sampling clock.
*/
module ccp_sync2 #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      meta_reg <= '0;
      q_out <= '0;
    end
    else
    begin
      meta_reg <= d_in;
      q_out <= meta_reg;
    end
  end
endmodule

// >>> core/ccp_top.sv
/*
  Control-channel proxy and status block: local I2C options (SDA delay,
  bus watchdog, remote-write block), peer and alias address handling,
  back-channel CRC error counting and link status.
  Assumes a decoded register port from the serial control bus slave on
  core_clk_in, and pins and link signals asynchronous to it.
*/
`include "ccp_params.svh"

module ccp_top #(
  parameter int WD_LONG_CYC = `CCP_WD_LONG_MS * `CCP_CLK_KHZ,
  parameter int WD_SHORT_CYC = `CCP_WD_SHORT_MS * `CCP_CLK_KHZ
) (
  // clock and reset
  input wire logic core_clk_in,
  input wire logic rst_b_in,
  // decoded register access
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic reg_remote_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // local I2C pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_low_req_in,
  output logic scl_out,
  output logic scl_oe_out,
  output logic sda_out,
  output logic sda_oe_out,
  output logic bus_free_out,
  // forwarding toward the far end
  input wire logic fwd_req_in,
  input wire logic [6:0] fwd_addr_in,
  output logic fwd_valid_out,
  output logic fwd_reject_out,
  output logic [6:0] fwd_addr_out,
  // link side
  input wire logic bc_clk_in,
  input wire logic bc_crc_err_in,
  input wire logic link_in,
  input wire logic rx_lock_in,
  input wire logic pclk_ok_in,
  input wire logic self_test_in,
  input wire logic [6:0] rx_peer_addr_in
);
  localparam int HALF_CYC = `CCP_WD_HALF_NS / `CCP_CLK_NS;

  logic [14:0] syn;
  logic bcc_s, crc_s, link_s, lock_s, pclk_s, stest_s, scl_s, sda_s;
  ccp_pkg::ccp_addr_t rxa_s;
  logic bcc_q, lock_q, stest_q, scl_q, sda_q;
  logic crc_rst_reg, wr_blk_reg, wd_fast_reg, wd_dis_reg, hold_reg;
  logic [1:0] sda_dly_reg;
  ccp_pkg::ccp_addr_t peer_addr_reg, tgt_reg, alias_reg;
  logic [15:0] cnt_reg;
  logic des_err_reg, stest_err_reg;
  logic wr_ok, bcc_rise, crc_ev, lock_rise, stest_rise, scl_fall, activity;
  ccp_pkg::ccp_wd_state_t wd_state_reg;
  logic [24:0] wd_cnt_reg, wd_lim;
  logic [7:0] half_reg;
  logic [3:0] pulse_reg, dly_cnt_reg, sda_cyc;
  logic dly_run_reg;

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_b_in);

  // every pin and link input except sda_low_req_in crosses in one bundle
  ccp_sync2 #(.W(15)) u_sync (
    .core_clk_in(core_clk_in),
    .rst_b_in(rst_b_in),
    .d_in({bc_clk_in, bc_crc_err_in, link_in, rx_lock_in, pclk_ok_in, self_test_in,
           scl_in, sda_in, rx_peer_addr_in}),
    .q_out(syn)
  );
  assign {bcc_s, crc_s, link_s, lock_s, pclk_s, stest_s, scl_s, sda_s, rxa_s} = syn;

  // edge history; resets low like the synchroniser, so no false SCL fall after reset
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      bcc_q <= 1'b0;
      lock_q <= 1'b0;
      stest_q <= 1'b0;
      scl_q <= 1'b0;
      sda_q <= 1'b0;
    end
    else
    begin
      bcc_q <= bcc_s;
      lock_q <= lock_s;
      stest_q <= stest_s;
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign bcc_rise = bcc_s && !bcc_q;
  assign crc_ev = bcc_rise && crc_s;
  assign lock_rise = lock_s && !lock_q;
  assign stest_rise = stest_s && !stest_q;
  assign scl_fall = scl_q && !scl_s;
  assign activity = (scl_s != scl_q) || (sda_s != sda_q);

  // far-end writes dropped while blocked; forwarding is a separate path
  assign wr_ok = reg_wr_in && !(reg_remote_in && wr_blk_reg); // see RULE_02

  // configuration and address registers written by software
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      crc_rst_reg <= 1'b0;
      sda_dly_reg <= 2'h0;
      wr_blk_reg <= 1'b0;
      wd_fast_reg <= 1'b0;
      wd_dis_reg <= 1'b0;
      tgt_reg <= `CCP_RST_ADDR;
      alias_reg <= `CCP_RST_ADDR;
    end
    else if (wr_ok)
    begin
      case (reg_addr_in)
        `CCP_OFF_CFG: crc_rst_reg <= reg_wdata_in[`CCP_CRC_RST_BIT]; // see RULE_19
        `CCP_OFF_BUS:
        begin
          sda_dly_reg <= reg_wdata_in[`CCP_SDA_DLY_HI:`CCP_SDA_DLY_LO];
          wr_blk_reg <= reg_wdata_in[`CCP_WR_BLK_BIT];
          wd_fast_reg <= reg_wdata_in[`CCP_WD_FAST_BIT];
          wd_dis_reg <= reg_wdata_in[`CCP_WD_DIS_BIT];
        end
        `CCP_OFF_TGT: tgt_reg <= reg_wdata_in[7:1];
        `CCP_OFF_ALIAS: alias_reg <= reg_wdata_in[7:1];
        default: ;
      endcase
    end
  end

  // peer address: software write beats the lock-time autoload
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      peer_addr_reg <= `CCP_RST_ADDR;
      hold_reg <= 1'b0;
    end
    else if (wr_ok && reg_addr_in == `CCP_OFF_PEER)
    begin
      peer_addr_reg <= reg_wdata_in[7:1]; // see RULE_11
      hold_reg <= reg_wdata_in[`CCP_HOLD_BIT];
    end
    else if (lock_rise && !hold_reg) // see RULE_09 RULE_10
      peer_addr_reg <= rxa_s;
  end

  a_peer_hold: assert property ( // see RULE_10
    hold_reg && !(wr_ok && reg_addr_in == `CCP_OFF_PEER) |=> $stable(peer_addr_reg))
    else $error("peer address moved while held");

  a_peer_autoload: assert property ( // see RULE_09
    lock_rise && !hold_reg && !(wr_ok && reg_addr_in == `CCP_OFF_PEER)
    |=> peer_addr_reg == $past(rxa_s))
    else $error("peer address not loaded at lock");

  a_remote_block: assert property ( // see RULE_02
    reg_wr_in && reg_remote_in && wr_blk_reg && reg_addr_in == `CCP_OFF_TGT
    |=> $stable(tgt_reg))
    else $error("blocked remote write changed a register");

  // register read data, unmapped offsets read zero
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      reg_rdata_out <= `CCP_RST_BYTE;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        `CCP_OFF_CFG: reg_rdata_out <= {2'h0, crc_rst_reg, 5'h00};
        `CCP_OFF_BUS: reg_rdata_out <= {3'h0, sda_dly_reg, wr_blk_reg, wd_fast_reg, wd_dis_reg};
        `CCP_OFF_PEER: reg_rdata_out <= {peer_addr_reg, hold_reg};
        `CCP_OFF_TGT: reg_rdata_out <= {tgt_reg, 1'b0};
        `CCP_OFF_ALIAS: reg_rdata_out <= {alias_reg, 1'b0};
        `CCP_OFF_CNT_LO: reg_rdata_out <= cnt_reg[7:0]; // see RULE_14
        `CCP_OFF_CNT_HI: reg_rdata_out <= cnt_reg[15:8]; // see RULE_14
        `CCP_OFF_STAT: reg_rdata_out <= {4'h0, stest_err_reg, pclk_s, des_err_reg, link_s}; // see RULE_16 RULE_18
        default: reg_rdata_out <= `CCP_RST_BYTE;
      endcase
    end
  end

  a_link_status: assert property ( // see RULE_18
    reg_rd_in && reg_addr_in == `CCP_OFF_STAT |=> reg_rdata_out[`CCP_ST_LINK] == $past(link_s))
    else $error("link status bit wrong");

  a_pclk_status: assert property ( // see RULE_16
    reg_rd_in && reg_addr_in == `CCP_OFF_STAT |=> reg_rdata_out[`CCP_ST_PCLK] == $past(pclk_s))
    else $error("pixel clock status bit wrong");

  // error counter saturates rather than wrapping to a misleading small value
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
      cnt_reg <= `CCP_RST_CNT;
    else if (crc_rst_reg) // see RULE_19
      cnt_reg <= `CCP_RST_CNT;
    else if (crc_ev && cnt_reg != `CCP_CNT_MAX) // see RULE_14
      cnt_reg <= cnt_reg + 16'h0001;
  end

  a_cnt_clear: assert property ( // see RULE_19
    crc_rst_reg |=> cnt_reg == `CCP_RST_CNT)
    else $error("counter not cleared by reset bit");

  // error flags; the level clear holds them low while it stands
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      des_err_reg <= 1'b0;
      stest_err_reg <= 1'b0;
    end
    else
    begin
      if (crc_rst_reg || !link_s) // see RULE_17
        des_err_reg <= 1'b0;
      else if (crc_ev && !stest_s)
        des_err_reg <= 1'b1;
      if (crc_rst_reg || !link_s || stest_rise) // see RULE_15
        stest_err_reg <= 1'b0;
      else if (crc_ev && stest_s)
        stest_err_reg <= 1'b1;
    end
  end

  a_des_flag: assert property ( // see RULE_17
    crc_ev && !stest_s && !crc_rst_reg && link_s |=> des_err_reg)
    else $error("normal error flag not set");

  a_stest_flag: assert property ( // see RULE_15
    (crc_rst_reg || !link_s || stest_rise) |=> !stest_err_reg)
    else $error("self-test error flag not cleared");

  // watchdog expiry count per speed setting
  assign wd_lim = wd_fast_reg ? 25'(WD_SHORT_CYC - 1) : 25'(WD_LONG_CYC - 1); // see RULE_04

  // bus watchdog: idle detection and nine-clock recovery
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      wd_state_reg <= ccp_pkg::ccp_wd_watch;
      wd_cnt_reg <= 25'h0000000;
      half_reg <= 8'h00;
      pulse_reg <= 4'h0;
      scl_oe_out <= 1'b0;
      bus_free_out <= 1'b0;
    end
    else if (wd_dis_reg) // see RULE_05
    begin
      wd_state_reg <= ccp_pkg::ccp_wd_watch;
      wd_cnt_reg <= 25'h0000000;
      half_reg <= 8'h00;
      pulse_reg <= 4'h0;
      scl_oe_out <= 1'b0;
      bus_free_out <= 1'b0;
    end
    else
    begin
      case (wd_state_reg)
        ccp_pkg::ccp_wd_watch:
        begin
          if (activity)
          begin
            wd_cnt_reg <= 25'h0000000;
            bus_free_out <= 1'b0;
          end
          else if (wd_cnt_reg == wd_lim)
          begin
            wd_cnt_reg <= 25'h0000000;
            if (sda_s)
              bus_free_out <= 1'b1; // see RULE_06
            else
            begin
              wd_state_reg <= ccp_pkg::ccp_wd_low; // see RULE_07
              scl_oe_out <= 1'b1;
              pulse_reg <= 4'h0;
              half_reg <= 8'h00;
            end
          end
          else if (!bus_free_out)
            wd_cnt_reg <= wd_cnt_reg + 25'h0000001;
        end
        ccp_pkg::ccp_wd_low:
        begin
          if (half_reg == 8'(HALF_CYC - 1))
          begin
            half_reg <= 8'h00;
            scl_oe_out <= 1'b0;
            wd_state_reg <= ccp_pkg::ccp_wd_high;
          end
          else
            half_reg <= half_reg + 8'h01;
        end
        ccp_pkg::ccp_wd_high:
        begin
          if (half_reg == 8'(HALF_CYC - 1))
          begin
            half_reg <= 8'h00;
            pulse_reg <= pulse_reg + 4'h1;
            // idle count was cleared at expiry and held through recovery, so the wait restarts cleanly
            if (pulse_reg == 4'(`CCP_WD_PULSES - 1)) // see RULE_07
              wd_state_reg <= ccp_pkg::ccp_wd_watch;
            else
            begin
              wd_state_reg <= ccp_pkg::ccp_wd_low;
              scl_oe_out <= 1'b1;
            end
          end
          else
            half_reg <= half_reg + 8'h01;
        end
        default: wd_state_reg <= ccp_pkg::ccp_wd_watch;
      endcase
    end
  end

  a_wd_off: assert property ( // see RULE_05
    wd_dis_reg |=> !scl_oe_out && !bus_free_out && wd_state_reg == ccp_pkg::ccp_wd_watch)
    else $error("watchdog acted while disabled");

  a_wd_ninth: assert property ( // see RULE_07
    wd_state_reg == ccp_pkg::ccp_wd_high && half_reg == 8'(HALF_CYC - 1)
    && pulse_reg == 4'(`CCP_WD_PULSES - 1) && !wd_dis_reg
    |=> wd_state_reg == ccp_pkg::ccp_wd_watch && !scl_oe_out)
    else $error("recovery did not stop after nine clocks");

  a_wd_free: assert property ( // see RULE_06
    wd_state_reg == ccp_pkg::ccp_wd_watch && !activity && wd_cnt_reg == wd_lim
    && sda_s && !wd_dis_reg |=> bus_free_out)
    else $error("idle bus not marked free");

  // SDA delay in cycles, least time rounded up
  assign sda_cyc = 4'((`CCP_SDA_BASE_NS + `CCP_SDA_STEP_NS * int'(sda_dly_reg)
                       + `CCP_CLK_NS - 1) / `CCP_CLK_NS); // see RULE_01

  // SDA drive follows the request a fixed time after each SCL fall
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      dly_cnt_reg <= 4'h0;
      dly_run_reg <= 1'b0;
      sda_oe_out <= 1'b0;
    end
    else if (scl_fall)
    begin
      dly_cnt_reg <= sda_cyc - 4'h2; // loading takes one edge, update one more
      dly_run_reg <= 1'b1;
    end
    else if (dly_run_reg)
    begin
      if (dly_cnt_reg == 4'h0)
      begin
        sda_oe_out <= sda_low_req_in; // see RULE_01
        dly_run_reg <= 1'b0;
      end
      else
        dly_cnt_reg <= dly_cnt_reg - 4'h1;
    end
  end

  a_sda_hold: assert property ( // see RULE_01
    scl_fall && sda_dly_reg == 2'h0 |=> $stable(sda_oe_out)[*4])
    else $error("SDA moved before the delay");

  a_sda_update: assert property ( // see RULE_01
    scl_fall && sda_dly_reg == 2'h0 |-> ##5 sda_oe_out == $past(sda_low_req_in))
    else $error("SDA not updated after the delay");

  // pin data lines only ever pull low
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
    else
    begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
    end
  end

  // forwarding decision; not gated by the remote-write block
  always_ff @(posedge core_clk_in or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      fwd_valid_out <= 1'b0;
      fwd_reject_out <= 1'b0;
      fwd_addr_out <= `CCP_RST_ADDR;
    end
    else
    begin
      fwd_valid_out <= 1'b0;
      fwd_reject_out <= 1'b0;
      if (fwd_req_in) // see RULE_03
      begin
        if (peer_addr_reg == `CCP_RST_ADDR) // see RULE_08
          fwd_reject_out <= 1'b1;
        else if (alias_reg != `CCP_RST_ADDR && fwd_addr_in == alias_reg) // see RULE_13
        begin
          fwd_valid_out <= 1'b1;
          fwd_addr_out <= tgt_reg; // see RULE_12
        end
        else if (fwd_addr_in == peer_addr_reg)
        begin
          fwd_valid_out <= 1'b1;
          fwd_addr_out <= fwd_addr_in;
        end
        else
          fwd_reject_out <= 1'b1;
      end
    end
  end

  a_fwd_remap: assert property ( // see RULE_12
    fwd_req_in && peer_addr_reg != `CCP_RST_ADDR && alias_reg != `CCP_RST_ADDR
    && fwd_addr_in == alias_reg |=> fwd_valid_out && fwd_addr_out == $past(tgt_reg))
    else $error("alias not remapped to target");

  a_peer_zero: assert property ( // see RULE_08
    fwd_req_in && peer_addr_reg == `CCP_RST_ADDR |=> !fwd_valid_out && fwd_reject_out)
    else $error("access with zero peer address");

  a_alias_zero: assert property ( // see RULE_13
    fwd_req_in && alias_reg == `CCP_RST_ADDR && fwd_addr_in != peer_addr_reg
    |=> !fwd_valid_out)
    else $error("access through zero alias");
endmodule

// >>> testbench/ccp_far_model.sv
/*
  Far-end model: back-channel clock and error flag, link, lock and the
  peer address sent at lock. Assumes the bench calls its tasks by name.
*/
module ccp_far_model (
  // toward the block
  output logic bc_clk_out,
  output logic crc_err_out,
  output logic link_out,
  output logic lock_out,
  output logic [6:0] peer_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // quiet link at time zero
  initial
  begin
    bc_clk_out = 1'b0;
    crc_err_out = 1'b0;
    link_out = 1'b0;
    lock_out = 1'b0;
    peer_out = 7'h00;
  end
  // clock runs only within frames; flag turned over after, as a released line
  task automatic frames(input int n, input logic err);
    for (int i = 0; i < n; i++)
    begin
      crc_err_out = err;
      #200 bc_clk_out = 1'b1;
      #200 bc_clk_out = 1'b0;
    end
    crc_err_out = ~err;
  endtask
  task automatic set_link(input logic v);
    link_out = v;
  endtask
  // address stable before lock rises; scrambled once lock is gone
  task automatic lock(input logic [6:0] a);
    peer_out = a;
    #400 lock_out = 1'b1;
  endtask
  task automatic unlock();
    lock_out = 1'b0;
    peer_out = ~peer_out;
  endtask
endmodule

// >>> testbench/tb_top.sv
/*
  Self-checking bench for the control-channel proxy block.
  Assumes the design files and ccp_params.svh are compiled alongside.
*/
`include "ccp_params.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // short watchdog counts keep the run brief
  localparam int LONG = 200;
  localparam int SHORT = 50;
  localparam int HALF = `CCP_WD_HALF_NS / `CCP_CLK_NS;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic remote = 1'b0;
  logic fwd_req = 1'b0;
  logic low_req = 1'b0;
  logic scl_drv = 1'b1;
  logic sda_drv = 1'b1;
  logic pclk_ok = 1'b0;
  logic self_test = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic [6:0] fwd_addr = 7'h00;
  logic [7:0] rdata;
  logic [6:0] fwd_addr_o;
  logic [6:0] peer;
  logic scl_oe, sda_oe, bus_free, fwd_valid, fwd_reject, scl_o, sda_o;
  logic bc_clk, crc_err, link, lock;
  int fail_count = 0;
  int compares = 0;
  // open-drain lines: low when anyone pulls
  wire logic scl_w = scl_drv & ~scl_oe;
  wire logic sda_w = sda_drv & ~sda_oe;

  ccp_top #(.WD_LONG_CYC(LONG), .WD_SHORT_CYC(SHORT)) dut (
    .core_clk_in(core_clk), .rst_b_in(rst_b),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_remote_in(remote),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .scl_in(scl_w), .sda_in(sda_w), .sda_low_req_in(low_req),
    .scl_out(scl_o), .scl_oe_out(scl_oe), .sda_out(sda_o), .sda_oe_out(sda_oe),
    .bus_free_out(bus_free), .fwd_req_in(fwd_req), .fwd_addr_in(fwd_addr),
    .fwd_valid_out(fwd_valid), .fwd_reject_out(fwd_reject), .fwd_addr_out(fwd_addr_o),
    .bc_clk_in(bc_clk), .bc_crc_err_in(crc_err), .link_in(link),
    .rx_lock_in(lock), .pclk_ok_in(pclk_ok), .self_test_in(self_test),
    .rx_peer_addr_in(peer));

  ccp_far_model far (.bc_clk_out(bc_clk), .crc_err_out(crc_err), .link_out(link),
    .lock_out(lock), .peer_out(peer));

  initial
  begin
    forever #25 core_clk = ~core_clk;
  end

  // inputs change 2 ns after the edge, never on it
  task automatic step(input int n = 1);
    repeat (n) @(posedge core_clk);
    #2;
  endtask
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    compares++;
    if (g !== e)
    begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  // one strobe cycle, then an idle edge so strobes never merge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d, input logic r = 1'b0);
    wr = 1'b1;
    remote = r;
    addr = a;
    wdata = d;
    step();
    wr = 1'b0;
    remote = 1'b0;
    step();
  endtask
  task automatic exp_reg(input logic [7:0] a, input logic [7:0] e);
    rd = 1'b1;
    addr = a;
    step();
    rd = 1'b0;
    step();
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, rdata});
  endtask
  task automatic fwd(input logic [6:0] a, input logic ok, input logic [6:0] e);
    fwd_req = 1'b1;
    fwd_addr = a;
    step();
    fwd_req = 1'b0;
    chk("fwd valid", {15'h0000, ok}, {15'h0000, fwd_valid});
    chk("fwd reject", {15'h0000, ~ok}, {15'h0000, fwd_reject});
    if (ok)
    begin
      chk("fwd addr", {9'h000, e}, {9'h000, fwd_addr_o});
    end
    step();
  endtask

  // reset values, unmapped places included
  task automatic t_reset();
    for (int a = 4; a < 14; a++)
    begin
      exp_reg(8'(a), 8'h00);
    end
  endtask
  task automatic t_regs();
    wr_reg(`CCP_OFF_ALIAS, 8'h43);
    exp_reg(`CCP_OFF_ALIAS, 8'h42);
    wr_reg(`CCP_OFF_CNT_LO, 8'h55);
    exp_reg(`CCP_OFF_CNT_LO, 8'h00);
    wr_reg(8'h09, 8'hFF);
    exp_reg(8'h09, 8'h00);
    wr_reg(`CCP_OFF_CFG, 8'hFF);
    step(10);
    exp_reg(`CCP_OFF_CFG, 8'h20);
    wr_reg(`CCP_OFF_CFG, 8'h00);
    wr_reg(`CCP_OFF_BUS, 8'h04);
    wr_reg(`CCP_OFF_TGT, 8'hB0, 1'b1);
    exp_reg(`CCP_OFF_TGT, 8'h00);
    wr_reg(`CCP_OFF_TGT, 8'hA0);
    exp_reg(`CCP_OFF_TGT, 8'hA0);
  endtask
  // block bit still set here: far-end reach of slaves unchanged
  task automatic t_fwd();
    fwd(7'h21, 1'b0, 7'h00);
    wr_reg(`CCP_OFF_PEER, {7'h30, 1'b1});
    fwd(7'h21, 1'b1, 7'h50);
    fwd(7'h30, 1'b1, 7'h30);
    fwd(7'h11, 1'b0, 7'h00);
    wr_reg(`CCP_OFF_ALIAS, 8'h00);
    fwd(7'h00, 1'b0, 7'h00);
    fwd(7'h21, 1'b0, 7'h00);
    wr_reg(`CCP_OFF_BUS, 8'h00);
    wr_reg(`CCP_OFF_TGT, 8'hC0, 1'b1);
    exp_reg(`CCP_OFF_TGT, 8'hC0);
  endtask
  task automatic t_peer();
    wr_reg(`CCP_OFF_PEER, 8'h00);
    far.lock(7'h3A);
    step(6);
    exp_reg(`CCP_OFF_PEER, 8'h74);
    far.unlock();
    wr_reg(`CCP_OFF_PEER, {7'h12, 1'b1});
    step(4);
    far.lock(7'h3A);
    step(6);
    exp_reg(`CCP_OFF_PEER, 8'h25);
    far.unlock();
  endtask
  task automatic t_crc();
    far.set_link(1'b1);
    pclk_ok = 1'b1;
    step(4);
    exp_reg(`CCP_OFF_STAT, 8'h05);
    far.frames(3, 1'b1);
    far.frames(2, 1'b0);
    step(4);
    exp_reg(`CCP_OFF_CNT_LO, 8'h03);
    exp_reg(`CCP_OFF_CNT_HI, 8'h00);
    exp_reg(`CCP_OFF_STAT, 8'h07);
    wr_reg(`CCP_OFF_CFG, 8'h20);
    far.frames(1, 1'b1);
    step(4);
    exp_reg(`CCP_OFF_CNT_LO, 8'h00);
    exp_reg(`CCP_OFF_STAT, 8'h05);
    wr_reg(`CCP_OFF_CFG, 8'h00);
    self_test = 1'b1;
    far.frames(1, 1'b1);
    step(4);
    exp_reg(`CCP_OFF_CNT_LO, 8'h01);
    exp_reg(`CCP_OFF_STAT, 8'h0D);
    self_test = 1'b0;
    step(4);
    self_test = 1'b1;
    step(4);
    exp_reg(`CCP_OFF_STAT, 8'h05);
    self_test = 1'b0;
    far.frames(1, 1'b1);
    step(4);
    far.set_link(1'b0);
    step(4);
    exp_reg(`CCP_OFF_STAT, 8'h04);
    pclk_ok = 1'b0;
    step(4);
    exp_reg(`CCP_OFF_STAT, 8'h00);
  endtask
  // bus activity, then idle cycles until the bus is called free
  task automatic idle_wait(output int n);
    sda_drv = 1'b0;
    step(2);
    sda_drv = 1'b1;
    step(4);
    n = 4;
    while (bus_free !== 1'b1 && n < 2 * LONG)
    begin
      step();
      n++;
    end
  endtask
  task automatic t_wdog();
    int n;
    int hits;
    logic prev;
    idle_wait(n);
    chk("slow expiry", 16'h0001, {15'h0000, n >= LONG && n <= LONG + 8});
    wr_reg(`CCP_OFF_BUS, 8'h02);
    idle_wait(n);
    chk("fast expiry", 16'h0001, {15'h0000, n >= SHORT && n <= SHORT + 8});
    wr_reg(`CCP_OFF_BUS, 8'h01);
    sda_drv = 1'b0;
    hits = 0;
    for (int i = 0; i < 2 * LONG; i++)
    begin
      step();
      hits += (scl_oe !== 1'b0 || bus_free !== 1'b0);
    end
    chk("disabled activity", 16'h0000, 16'(hits));
    wr_reg(`CCP_OFF_BUS, 8'h00);
    hits = 0;
    prev = 1'b0;
    for (int i = 0; i < LONG + 18 * HALF + 100; i++)
    begin
      step();
      hits += (scl_oe === 1'b1 && prev !== 1'b1) ? 1 : 0;
      prev = scl_oe;
    end
    chk("recovery clocks", 16'(`CCP_WD_PULSES), 16'(hits));
    chk("pin data", 16'h0000, {14'h0000, scl_o, sda_o});
    sda_drv = 1'b1;
    step(4);
  endtask
  // watchdog off so a held SDA never triggers recovery
  task automatic t_sda();
    int d [4];
    for (int k = 0; k < 4; k++)
    begin
      wr_reg(`CCP_OFF_BUS, {3'b000, 2'(k), 3'b001});
      step(4);
      scl_drv = 1'b0;
      low_req = 1'b1;
      d[k] = 0;
      while (sda_oe !== 1'b1 && d[k] < 30)
      begin
        step();
        d[k]++;
      end
      chk("sda step", 16'(k), 16'(d[k] - d[0]));
      // SDA drive only changes on a fall, so a second fall without request lets go
      low_req = 1'b0;
      scl_drv = 1'b1;
      step(4);
      scl_drv = 1'b0;
      step(14);
      chk("sda release", 16'h0000, {15'h0000, sda_oe});
      scl_drv = 1'b1;
      step(4);
    end
    chk("sda base", 16'h0001, {15'h0000, d[0] >= 5 && d[0] <= 10});
    wr_reg(`CCP_OFF_BUS, 8'h00);
  endtask

  task automatic wrap_up();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
    begin
      $display("DONE - PASS");
    end
    else
    begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // main sequence
  initial
  begin
    step(12);
    rst_b = 1'b1;
    step();
    t_reset();
    t_regs();
    t_fwd();
    t_peer();
    t_crc();
    t_wdog();
    t_sda();
    wrap_up();
  end
  // run needs about 3200 cycles; cut off well beyond
  initial
  begin
    #2000000;
    fail_count++;
    wrap_up();
  end
endmodule
